// [rtl/usi_map.svh]
// Register indices, field positions, mode values and timing counts
`ifndef USI_MAP_SVH
`define USI_MAP_SVH
// Register indices; the byte address is four times the index
`define USI_IDX_PORT_A 10'h0B0
`define USI_IDX_PORT_B 10'h0B1
`define USI_IDX_ADDR 10'h0B2
`define USI_IDX_PIN_MODE 10'h0B3
`define USI_IDX_CTRL 10'h0B4
`define USI_IDX_LOW_FLAGS 10'h0B5
`define USI_IDX_LOW_EN 10'h0B6
`define USI_IDX_HIGH_FLAGS 10'h0B7
`define USI_IDX_HIGH_EN 10'h0B8
`define USI_IDX_EP0_STAT 10'h0B9
`define USI_IDX_EPX_STAT 10'h0BA
`define USI_IDX_DIR_A 10'h0BD
`define USI_IDX_DIR_B 10'h0BE
// Pin mode values
`define USI_MODE_GPIO 8'h00
`define USI_MODE_USB 8'h01
`define USI_MODE_PS2 8'h02
`define USI_MODE_SERIAL 8'h04
// Control and status bit positions
`define USI_CTRL_POWER 7
`define USI_CTRL_RESUME 6
`define USI_CTRL_ACTIVITY 5
`define USI_CTRL_JSTATE 4
// High priority flag positions
`define USI_HI_WAKE 7
`define USI_HI_NAK_EP1 6
`define USI_HI_NAK_EP0 5
`define USI_HI_STALL_EP0 2
`define USI_HI_CONTROL_SETUP_FLAG_EP0 0
// Endpoint status bit positions
`define USI_EP0_IN_ARM 1
`define USI_EP0_FORCE_NAK 2
`define USI_EP0_OUT_REL 5
// Serial line timing
`define USI_SYS_HZ 125000000
`define USI_BAUD 1200
`define USI_BAUD_CNT_W 17
`endif

// [rtl/usi_pkg.sv]
// Types shared by the register interface and its surroundings
package usi_pkg;

  // Answer kinds handed back to the transaction engine
  typedef enum logic [1:0] {
    USI_RSP_ACK,
    USI_RSP_NAK,
    USI_RSP_DATA
  } usi_resp_code_type;

  // Engine drive onto the bus lines
  typedef struct packed {
    logic dp;
    logic dm;
    logic oe;
  } usi_line_type;

  // Transaction events reported by the engine, one cycle each
  typedef struct packed {
    logic [2:0] inToken;
    logic [2:0] inAcked;
    logic [2:0] outPkt;
    logic [3:0] outLen;
    logic [2:0] stallSent;
    logic [1:0] setupDone;
    logic busReset;
  } usi_event_type;

  // Answer to the engine
  typedef struct packed {
    logic valid;
    usi_resp_code_type code;
  } usi_resp_type;

  // Whole state of the register interface
  typedef struct packed {
    logic [7:0] portA;
    logic [7:0] portB;
    logic [7:0] dirA;
    logic [7:0] dirB;
    logic [6:0] addr;
    logic [7:0] pinMode;
    logic power;
    logic forceResume;
    logic activity;
    logic [2:0] epCfg;
    logic [7:0] lowFlags;
    logic [7:0] lowEn;
    logic [7:0] highFlags;
    logic [7:0] highEn;
    logic [2:0] inArmed;
    logic [2:0] outReleased;
    logic [11:0] outCount;
    logic [1:0] lineLast;
    logic engRst;
    usi_resp_type resp;
    logic [31:0] rdata;
    logic [9:0] txShift;
    logic [3:0] txBits;
    logic [16:0] txCnt;
    logic [7:0] rxShift;
    logic [3:0] rxBits;
    logic [16:0] rxCnt;
    logic [7:0] rxData;
    logic rxValid;
  } usi_state_type;

endpackage : usi_pkg

// [rtl/usi_register_interface.sv]
// Register interface, pin mode selector and flag logic of the bus engine
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "usi_map.svh"

// Behaviour
// - Port data reads return pin levels; writes store output data.
// - Device address is read/write, cleared by bus reset and power-on.
// - Pin mode register picks GPIO, USB, PS/2 or serial; others reserved.
// - GPIO mode disables the engine; both lines are ordinary pins.
// - USB mode: upper pin is D+, lower pin is D-.
// - PS/2: upper clock, lower data, open-drain, clock pull-up offered.
// - Serial: transmit upper, receive lower, 1200 baud, 8N1.
// - Force-resume bit drives the K state onto the bus lines.
// - Activity bit set on any line change in USB mode; firmware reads and writes it.
// - Wake flag set whenever the activity bit becomes set.
// - Line-state bit reads one in J, zero in K or SE0.
// - Three-bit endpoint configuration selects non-zero endpoint layout.
// - Writing a different configuration resets the engine; same value not.
// - Low flags depend on configuration; write one clears, zero keeps.
// - Low four bits are EP0 flags; upper pairs follow configuration.
// - Mask bit one unmasks a source, zero suppresses it.
// - Acked IN sets IN-complete, clearing IN-armed and IN-NAKed.
// - IN token with IN-armed clear is NAKed and sets IN-NAKed.
// - Valid OUT stores count, ACKs, sets received, clears released, NAKed.
// - OUT with released clear is NAKed, sets OUT-NAKed, keeps data.
// - Stall-sent flags per endpoint; EP1 one in configurations 001 to 111, EP2 one in 100 to 111.
// - Setup flags for EP0 always, for EP1 only in configuration 011.
// - High flags hold wake, NAK, stall and setup; write one clears.
module usi_register_interface
  import usi_pkg::*;
#(
  parameter int BAUD_CYCLES = `USI_SYS_HZ / `USI_BAUD
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] portAIn,
  output logic [7:0] portAOut,
  output logic [7:0] portAOe,
  input wire logic [7:0] portBIn,
  output logic [7:0] portBOut,
  output logic [7:0] portBOe,
  output logic ps2ClkPullup,
  input wire logic ps2ClkLow,
  input wire logic ps2DataLow,
  output logic engineEnable,
  output logic engineReset,
  output logic [6:0] deviceAddress,
  output logic [2:0] epConfig,
  input wire usi_line_type engLine,
  input wire usi_event_type engEvent,
  output usi_resp_type engResp,
  input wire logic [7:0] serTxData,
  input wire logic serTxValid,
  output logic serTxReady,
  output logic [7:0] serRxData,
  output logic serRxValid,
  output logic lowIrq,
  output logic highIrq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (BAUD_CYCLES < 4 ||
      BAUD_CYCLES >= (1 << `USI_BAUD_CNT_W)) begin : baudCheck
    $error("BAUD_CYCLES out of counter range");
  end

  localparam logic [16:0] BAUD_LAST = 17'(BAUD_CYCLES - 1);
  localparam logic [16:0] BAUD_HALF = 17'(BAUD_CYCLES / 2);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Register index hit for a byte address
  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    hit = (a[11:2] == idx);
  endfunction : hit

  // Low flag pair base for an endpoint and direction: {valid, base}
  function automatic logic [3:0] pairOf(input logic [2:0] cfg,
                                        input int ep, input logic isIn);
    pairOf = 4'h0;
    if (ep == 0) begin
      pairOf = isIn ? 4'h8 : 4'hA;
    end else if (ep == 1) begin
      unique case (cfg)
        3'h1, 3'h7: pairOf = isIn ? 4'hC : 4'h0;
        3'h2, 3'h4: pairOf = isIn ? 4'h0 : 4'hC;
        3'h3, 3'h5: pairOf = isIn ? 4'hC : 4'hE;
        3'h6: pairOf = isIn ? 4'hE : 4'hC;
        default: pairOf = 4'h0;
      endcase
    end else begin
      if (cfg == 3'h4 && !isIn) begin
        pairOf = 4'hE;
      end else if (cfg == 3'h7 && isIn) begin
        pairOf = 4'hE;
      end
    end
  endfunction : pairOf

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  usi_state_type st;
  usi_state_type next_st;

  logic wrAcc;
  logic rdSetup;
  logic anyHit;
  logic usbMode;
  logic lineJ;
  logic [31:0] wData;
  logic [31:0] rdValue;

  assign wrAcc = psel && penable && pwrite;
  assign rdSetup = psel && !penable && !pwrite;
  assign wData = pwdata;
  assign usbMode = (st.pinMode == `USI_MODE_USB);
  // J on a low-speed bus: D+ low, D- high
  assign lineJ = !portBIn[7] && portBIn[6];

  // Mapped address test
  always_comb begin
    anyHit = 1'b0;
    for (int i = 'h0B0; i <= 'h0BA; i++) begin
      if (hit(paddr, 10'(i))) begin
        anyHit = 1'b1;
      end
    end
    if (hit(paddr, `USI_IDX_DIR_A) || hit(paddr, `USI_IDX_DIR_B)) begin
      anyHit = 1'b1;
    end
  end

  // Read data selection
  always_comb begin
    rdValue = 32'h0000_0000;
    if (hit(paddr, `USI_IDX_PORT_A)) rdValue[7:0] = portAIn;
    if (hit(paddr, `USI_IDX_PORT_B)) rdValue[7:0] = portBIn;
    if (hit(paddr, `USI_IDX_ADDR)) rdValue[6:0] = st.addr;
    if (hit(paddr, `USI_IDX_PIN_MODE)) rdValue[7:0] = st.pinMode;
    if (hit(paddr, `USI_IDX_CTRL)) begin
      rdValue[7:0] = {st.power, st.forceResume, st.activity, lineJ,
                      1'b0, st.epCfg};
    end
    if (hit(paddr, `USI_IDX_LOW_FLAGS)) rdValue[7:0] = st.lowFlags;
    if (hit(paddr, `USI_IDX_LOW_EN)) rdValue[7:0] = st.lowEn;
    if (hit(paddr, `USI_IDX_HIGH_FLAGS)) rdValue[7:0] = st.highFlags;
    if (hit(paddr, `USI_IDX_HIGH_EN)) rdValue[7:0] = st.highEn;
    if (hit(paddr, `USI_IDX_EP0_STAT)) begin
      rdValue[`USI_EP0_OUT_REL] = st.outReleased[0];
      rdValue[`USI_EP0_IN_ARM] = st.inArmed[0];
    end
    if (hit(paddr, `USI_IDX_EPX_STAT)) begin
      rdValue[3:0] = {st.outReleased[2], st.inArmed[2],
                      st.outReleased[1], st.inArmed[1]};
    end
    if (hit(paddr, `USI_IDX_DIR_A)) rdValue[7:0] = st.dirA;
    if (hit(paddr, `USI_IDX_DIR_B)) rdValue[7:0] = st.dirB;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] lowSet;
    logic [7:0] highSet;
    logic [3:0] pr;
    logic on;
    lowSet = 8'h00;
    highSet = 8'h00;
    pr = 4'h0;
    on = 1'b0;
    next_st = st;
    next_st.engRst = 1'b0;
    next_st.resp = '{valid: 1'b0, code: USI_RSP_ACK};
    next_st.rxValid = 1'b0;
    on = st.power && usbMode;

    // Register writes
    if (wrAcc) begin
      if (hit(paddr, `USI_IDX_PORT_A)) next_st.portA = wData[7:0];
      if (hit(paddr, `USI_IDX_PORT_B)) next_st.portB = wData[7:0];
      if (hit(paddr, `USI_IDX_ADDR)) next_st.addr = wData[6:0];
      if (hit(paddr, `USI_IDX_PIN_MODE)) next_st.pinMode = wData[7:0];
      if (hit(paddr, `USI_IDX_CTRL)) begin
        next_st.power = wData[`USI_CTRL_POWER];
        next_st.forceResume = wData[`USI_CTRL_RESUME];
        next_st.activity = wData[`USI_CTRL_ACTIVITY];
        next_st.epCfg = wData[2:0];
        next_st.engRst = (wData[2:0] != st.epCfg);
      end
      if (hit(paddr, `USI_IDX_LOW_FLAGS)) begin
        next_st.lowFlags = st.lowFlags & ~wData[7:0];
      end
      if (hit(paddr, `USI_IDX_LOW_EN)) next_st.lowEn = wData[7:0];
      if (hit(paddr, `USI_IDX_HIGH_FLAGS)) begin
        next_st.highFlags = st.highFlags & ~wData[7:0];
      end
      if (hit(paddr, `USI_IDX_HIGH_EN)) next_st.highEn = wData[7:0];
      if (hit(paddr, `USI_IDX_EP0_STAT)) begin
        if (wData[`USI_EP0_FORCE_NAK]) begin
          next_st.inArmed[0] = 1'b0;
          next_st.outReleased[0] = 1'b0;
        end
        if (wData[`USI_EP0_IN_ARM]) next_st.inArmed[0] = 1'b1;
        if (wData[`USI_EP0_OUT_REL]) next_st.outReleased[0] = 1'b1;
      end
      if (hit(paddr, `USI_IDX_EPX_STAT)) begin
        for (int e = 1; e <= 2; e++) begin
          if (wData[3 + e]) begin
            next_st.inArmed[e] = 1'b0;
            next_st.outReleased[e] = 1'b0;
          end
          if (wData[2 * e - 2]) next_st.inArmed[e] = 1'b1;
          if (wData[2 * e - 1]) next_st.outReleased[e] = 1'b1;
        end
      end
      if (hit(paddr, `USI_IDX_DIR_A)) next_st.dirA = wData[7:0];
      if (hit(paddr, `USI_IDX_DIR_B)) next_st.dirB = wData[7:0];
    end

    // Line change detection in bus mode
    next_st.lineLast = portBIn[7:6];
    if (usbMode && portBIn[7:6] != st.lineLast) begin
      next_st.activity = 1'b1;
    end
    if (next_st.activity && !st.activity) begin
      highSet[`USI_HI_WAKE] = 1'b1;
    end

    // Endpoint transactions, one event per endpoint per cycle
    if (on) begin
      for (int e = 0; e <= 2; e++) begin
        pr = pairOf(st.epCfg, e, 1'b1);
        if (engEvent.inToken[e] && pr[3]) begin
          next_st.resp.valid = 1'b1;
          if (st.inArmed[e]) begin
            next_st.resp.code = USI_RSP_DATA;
          end else begin
            next_st.resp.code = USI_RSP_NAK;
            lowSet[pr[2:0] + 3'h1] = 1'b1;
            if (e == 0) highSet[`USI_HI_NAK_EP0] = 1'b1;
            else highSet[`USI_HI_NAK_EP1] = 1'b1;
          end
        end
        if (engEvent.inAcked[e] && pr[3]) begin
          lowSet[pr[2:0]] = 1'b1;
          next_st.lowFlags[pr[2:0] + 3'h1] = 1'b0;
          next_st.inArmed[e] = 1'b0;
        end
        pr = pairOf(st.epCfg, e, 1'b0);
        if (engEvent.outPkt[e] && pr[3]) begin
          next_st.resp.valid = 1'b1;
          if (st.outReleased[e]) begin
            next_st.resp.code = USI_RSP_ACK;
            next_st.outCount[4 * e +: 4] = engEvent.outLen;
            lowSet[pr[2:0]] = 1'b1;
            next_st.lowFlags[pr[2:0] + 3'h1] = 1'b0;
            next_st.outReleased[e] = 1'b0;
          end else begin
            next_st.resp.code = USI_RSP_NAK;
            lowSet[pr[2:0] + 3'h1] = 1'b1;
            if (e == 0) highSet[`USI_HI_NAK_EP0] = 1'b1;
            else highSet[`USI_HI_NAK_EP1] = 1'b1;
          end
        end
      end
      // Stall and setup flags; EP1 and EP2 ones gated by configuration
      highSet[`USI_HI_STALL_EP0] = engEvent.stallSent[0];
      highSet[3] = engEvent.stallSent[1] && st.epCfg != 3'h0;
      highSet[4] = engEvent.stallSent[2] && st.epCfg[2];
      highSet[`USI_HI_CONTROL_SETUP_FLAG_EP0] = engEvent.setupDone[0];
      highSet[1] = engEvent.setupDone[1] && st.epCfg == 3'h3;
    end

    // Set wins over a clear in the same cycle
    next_st.lowFlags = next_st.lowFlags | lowSet;
    next_st.highFlags = next_st.highFlags | highSet;

    // Engine reset drops endpoint handshake state
    if (st.engRst) begin
      next_st.inArmed = 3'h0;
      next_st.outReleased = 3'h0;
      next_st.outCount = 12'h000;
    end
    if (engEvent.busReset && usbMode) next_st.addr = 7'h00;

    // Serial transmitter, 8N1
    if (st.txBits == 4'h0) begin
      if (serTxValid && st.pinMode == `USI_MODE_SERIAL) begin
        next_st.txShift = {1'b1, serTxData, 1'b0};
        next_st.txBits = 4'hA;
        next_st.txCnt = BAUD_LAST;
      end
    end else if (st.txCnt == 17'h0_0000) begin
      next_st.txShift = {1'b1, st.txShift[9:1]};
      next_st.txBits = st.txBits - 4'h1;
      next_st.txCnt = BAUD_LAST;
    end else begin
      next_st.txCnt = st.txCnt - 17'h0_0001;
    end

    // Serial receiver, sampled mid-bit
    if (st.rxBits == 4'h0) begin
      if (st.pinMode == `USI_MODE_SERIAL && !portBIn[6]) begin
        next_st.rxBits = 4'hA;
        next_st.rxCnt = BAUD_HALF;
      end
    end else if (st.rxCnt == 17'h0_0000) begin
      next_st.rxCnt = BAUD_LAST;
      next_st.rxBits = st.rxBits - 4'h1;
      if (st.rxBits == 4'hA && portBIn[6]) begin
        next_st.rxBits = 4'h0; // False start
      end else if (st.rxBits == 4'h1) begin
        next_st.rxValid = portBIn[6]; // Stop bit must be high
        if (portBIn[6]) next_st.rxData = st.rxShift;
      end else if (st.rxBits != 4'hA) begin
        next_st.rxShift = {portBIn[6], st.rxShift[7:1]};
      end
    end else begin
      next_st.rxCnt = st.rxCnt - 17'h0_0001;
    end

    // Read data captured in the setup phase
    if (rdSetup) next_st.rdata = anyHit ? rdValue : 32'h0000_0000;
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Bus answers with no wait states
  assign pready = 1'b1;
  assign pslverr = psel && penable && !anyHit;
  assign prdata = st.rdata;

  assign portAOut = st.portA;
  assign portAOe = st.dirA;
  assign deviceAddress = st.addr;
  assign epConfig = st.epCfg;
  assign engineEnable = st.power && usbMode;
  assign engineReset = st.engRst;
  assign engResp = st.resp;
  assign serTxReady = (st.txBits == 4'h0) && st.pinMode == `USI_MODE_SERIAL;
  assign serRxData = st.rxData;
  assign serRxValid = st.rxValid;
  assign ps2ClkPullup = (st.pinMode == `USI_MODE_PS2);
  assign lowIrq = |(st.lowFlags & st.lowEn);
  assign highIrq = |(st.highFlags & st.highEn);

  // Pin mode multiplexer for the two upper port B pins
  always_comb begin
    portBOut = st.portB;
    portBOe = st.dirB;
    unique case (st.pinMode)
      `USI_MODE_USB: begin
        if (st.forceResume) begin
          portBOut[7:6] = 2'b10;
          portBOe[7:6] = 2'b11;
        end else begin
          portBOut[7:6] = {engLine.dp, engLine.dm};
          portBOe[7:6] = {2{engLine.oe && engineEnable}};
        end
      end
      `USI_MODE_PS2: begin
        portBOut[7:6] = 2'b00;
        portBOe[7:6] = {ps2ClkLow, ps2DataLow};
      end
      `USI_MODE_SERIAL: begin
        portBOut[7:6] = {(st.txBits == 4'h0) | st.txShift[0], 1'b0};
        portBOe[7:6] = 2'b10;
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  addr_reset_a: assert property (engEvent.busReset && usbMode
    |=> deviceAddress == 7'h00) else $error("address not cleared");
  force_k_a: assert property (usbMode && st.forceResume
    |-> portBOut[7:6] == 2'b10 && portBOe[7:6] == 2'b11)
    else $error("resume K not driven");
  wake_flag_a: assert property ($rose(st.activity)
    |-> st.highFlags[`USI_HI_WAKE]) else $error("wake flag missing");
  jstate_read_a: assert property (rdSetup && hit(paddr, `USI_IDX_CTRL)
    |=> prdata[`USI_CTRL_JSTATE] == $past(lineJ))
    else $error("line state read wrong");
  cfg_reset_a: assert property (wrAcc && hit(paddr, `USI_IDX_CTRL)
    |=> engineReset == ($past(pwdata[2:0]) != $past(st.epCfg)))
    else $error("engine reset wrong");
  irq_level_a: assert property (wrAcc && hit(paddr, `USI_IDX_HIGH_EN)
    && (st.highFlags & pwdata[7:0]) != 8'h00 |=> highIrq)
    else $error("high request missing");
  in_nak_a: assert property (engineEnable && engEvent.inToken[0]
    && !st.inArmed[0] |=> st.lowFlags[1] && engResp.valid
    && engResp.code == USI_RSP_NAK) else $error("IN NAK missing");
  in_done_a: assert property (engineEnable && engEvent.inAcked[0]
    && !engEvent.inToken[0] |=> st.lowFlags[0] && !st.lowFlags[1]
    && !st.inArmed[0]) else $error("IN done wrong");
  out_rx_a: assert property (engineEnable && engEvent.outPkt[0]
    && st.outReleased[0] && !st.engRst |=> st.lowFlags[2]
    && !st.outReleased[0] && st.outCount[3:0] == $past(engEvent.outLen))
    else $error("OUT receive wrong");
  out_nak_a: assert property (engineEnable && engEvent.outPkt[0]
    && !st.outReleased[0] && !st.engRst |=> st.lowFlags[3]
    && $stable(st.outCount[3:0])) else $error("OUT NAK wrong");
  w1c_low_a: assert property (wrAcc && hit(paddr, `USI_IDX_LOW_FLAGS)
    && (engEvent == '0 || !engineEnable)
    |=> (st.lowFlags & $past(pwdata[7:0])) == 8'h00)
    else $error("flag not cleared");

endmodule : usi_register_interface

// [sim/usi_host_model.sv]
// Host-side model raising engine events on request
`timescale 1ns/1ps
module usi_host_model
  import usi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [2:0] kind,
  input wire logic [1:0] ep,
  output usi_event_type ev
);
  // One-cycle event pulse per request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev <= '0;
    end else begin
      ev <= '0;
      if (go) begin
        case (kind)
          3'h0: ev.inToken[ep] <= 1'b1;
          3'h1: ev.inAcked[ep] <= 1'b1;
          3'h2: begin
            ev.outPkt[ep] <= 1'b1;
            ev.outLen <= 4'h8;
          end
          3'h3: ev.stallSent[ep] <= 1'b1;
          3'h4: ev.setupDone[ep[0]] <= 1'b1;
          default: ev.busReset <= 1'b1;
        endcase
      end
    end
  end
endmodule : usi_host_model

// [sim/usb_sie_register_interface_tb.sv]
// Self-checking bench of the register interface
`timescale 1ns/1ps
`include "usi_map.svh"
module usb_sie_register_interface_tb
  import usi_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, err;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, serTxValid = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata, rnd = 32'h94B3;
  logic [7:0] pinA = 8'h00, serTxData = 8'h00, serRxData;
  logic [7:0] portAOut, portAOe, portBOut, portBOe;
  logic [1:0] hostLines = 2'b01, ep = 2'h0, ps2Low = 2'b00;
  logic [2:0] kind = 3'h0, epConfig;
  logic [5:0] pinB = 6'h00;
  logic [6:0] deviceAddress;
  logic [9:0] frame;
  logic [7:0] md [5] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h03};
  logic pready, pslverr, ps2ClkPullup, engineEnable, engineReset;
  logic serTxReady, serRxValid, lowIrq, highIrq;
  wire logic [7:0] portAIn, portBIn;
  usi_event_type engEvent;
  usi_resp_type engResp;
  int failCount = 0, checks = 0, rstCnt = 0, rxSeen = 0;
  // Pin levels from every party's drive
  assign portAIn = (portAOe & portAOut) | (~portAOe & pinA);
  assign portBIn = (portBOe & portBOut) | (~portBOe & {hostLines, pinB});
  usi_register_interface #(.BAUD_CYCLES(8)) usi_register_interface_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .portAIn(portAIn),
    .portAOut(portAOut), .portAOe(portAOe), .portBIn(portBIn),
    .portBOut(portBOut), .portBOe(portBOe), .ps2ClkPullup(ps2ClkPullup),
    .ps2ClkLow(ps2Low[1]), .ps2DataLow(ps2Low[0]),
    .engineEnable(engineEnable),
    .engineReset(engineReset), .deviceAddress(deviceAddress),
    .epConfig(epConfig), .engLine('0), .engEvent(engEvent),
    .engResp(engResp), .serTxData(serTxData), .serTxValid(serTxValid),
    .serTxReady(serTxReady), .serRxData(serRxData),
    .serRxValid(serRxValid), .lowIrq(lowIrq), .highIrq(highIrq));
  usi_host_model usi_host_model_i (.clk(clk), .rst_n(rst_n), .go(go),
    .kind(kind), .ep(ep), .ev(engEvent));
  // Clock and engine reset pulse count
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (engineReset === 1'b1) rstCnt++;
    if (serRxValid === 1'b1) rxSeen++;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failCount++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic finishTest;
    $display("checks %0d failures %0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finishTest
  // APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [9:0] ix, input logic [7:0] e);
    apb(1'b0, ix, 8'h00);
    chk("reg", {24'h0, e}, rd);
  endtask : rdc
  // Engine event; returns in the cycle its answer stands
  task automatic fire(input logic [2:0] k, input logic [1:0] e);
    @(posedge clk);
    kind <= k;
    ep <= e;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask : fire
  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    finishTest;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`USI_IDX_ADDR, 8'h00);
    apb(1'b0, 10'h0BF, 8'h00);
    chk("slverr", 32'h1, err);
    // Port reads show pins, not the stored value
    rnd = lfsr(rnd);
    pinA <= rnd[7:0];
    apb(1'b1, `USI_IDX_PORT_A, ~rnd[7:0]);
    rdc(`USI_IDX_PORT_A, rnd[7:0]);
    apb(1'b1, `USI_IDX_DIR_A, 8'hFF);
    rdc(`USI_IDX_PORT_A, ~rnd[7:0]);
    apb(1'b1, `USI_IDX_ADDR, rnd[15:8] & 8'h7F);
    rdc(`USI_IDX_ADDR, rnd[15:8] & 8'h7F);
    chk("devAddr", rnd[15:8] & 8'h7F, deviceAddress);
    // Every pin mode with the engine powered
    apb(1'b1, `USI_IDX_CTRL, 8'h80);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `USI_IDX_PIN_MODE, md[i]);
      rdc(`USI_IDX_PIN_MODE, md[i]);
      chk("pullup", md[i] == 8'h02, ps2ClkPullup);
      chk("enable", md[i] == 8'h01, engineEnable);
    end
    // Open-drain lines follow the pull-low requests
    ps2Low <= rnd[17:16];
    apb(1'b1, `USI_IDX_PIN_MODE, 8'h02);
    @(negedge clk);
    chk("ps2pins", {28'h0, ps2Low, 2'b00},
        {28'h0, portBOe[7:6], portBOut[7:6]});
    // Serial byte, LSB first, framed
    apb(1'b1, `USI_IDX_PIN_MODE, 8'h04);
    rnd = lfsr(rnd);
    frame = {1'b1, rnd[7:0], 1'b0};
    serTxData <= rnd[7:0];
    serTxValid <= 1'b1;
    do begin
      @(posedge clk);
    end while (serTxReady !== 1'b1);
    serTxValid <= 1'b0;
    repeat (4) @(posedge clk);
    for (int b = 0; b < 10; b++) begin
      @(negedge clk);
      chk("txbit", frame[b], portBOut[7]);
      repeat (7) @(negedge clk);
    end
    // Serial byte into the receive pin, one bit per baud period
    rnd = lfsr(rnd);
    frame = {1'b1, rnd[7:0], 1'b0};
    @(posedge clk);
    for (int b = 0; b < 10; b++) begin
      hostLines[0] <= frame[b];
      repeat (8) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    chk("rxData", rnd[7:0], serRxData);
    chk("rxValid", 32'h1, rxSeen);
    // Line state, activity and wake
    apb(1'b1, `USI_IDX_PIN_MODE, 8'h01);
    // Pins released by the serial driver count as a change
    apb(1'b1, `USI_IDX_CTRL, 8'h80);
    apb(1'b1, `USI_IDX_HIGH_FLAGS, 8'hFF);
    rdc(`USI_IDX_CTRL, 8'h90);
    hostLines <= 2'b10;
    rdc(`USI_IDX_CTRL, 8'hA0);
    rdc(`USI_IDX_HIGH_FLAGS, 8'h80);
    apb(1'b1, `USI_IDX_CTRL, 8'hC0);
    @(negedge clk);
    chk("pinsK", 4'hE, {portBOe[7:6], portBOut[7:6]});
    apb(1'b1, `USI_IDX_CTRL, 8'h80);
    rdc(`USI_IDX_CTRL, 8'h80);
    apb(1'b1, `USI_IDX_HIGH_FLAGS, 8'hFF);
    rdc(`USI_IDX_HIGH_FLAGS, 8'h00);
    apb(1'b1, `USI_IDX_CTRL, 8'h83);
    apb(1'b1, `USI_IDX_CTRL, 8'h83);
    chk("engRst", 32'h1, rstCnt);
    chk("epConfig", 32'h3, epConfig);
    // EP0 IN unarmed, flags, masks
    fire(3'h0, 2'h0);
    chk("resp", {1'b1, USI_RSP_NAK}, engResp);
    rdc(`USI_IDX_LOW_FLAGS, 8'h02);
    rdc(`USI_IDX_HIGH_FLAGS, 8'h20);
    apb(1'b1, `USI_IDX_LOW_FLAGS, 8'h00);
    rdc(`USI_IDX_LOW_FLAGS, 8'h02);
    chk("lowIrq", 32'h0, lowIrq);
    apb(1'b1, `USI_IDX_LOW_EN, 8'h02);
    @(negedge clk);
    chk("lowIrq", 32'h1, lowIrq);
    chk("highIrq", 32'h0, highIrq);
    apb(1'b1, `USI_IDX_HIGH_EN, 8'h20);
    @(negedge clk);
    chk("highIrq", 32'h1, highIrq);
    // Armed IN, then host acknowledge
    apb(1'b1, `USI_IDX_EP0_STAT, 8'h02);
    fire(3'h0, 2'h0);
    chk("resp", {1'b1, USI_RSP_DATA}, engResp);
    fire(3'h1, 2'h0);
    rdc(`USI_IDX_LOW_FLAGS, 8'h01);
    rdc(`USI_IDX_EP0_STAT, 8'h00);
    // OUT refused, then released and taken
    apb(1'b1, `USI_IDX_LOW_FLAGS, 8'hFF);
    fire(3'h2, 2'h0);
    chk("resp", {1'b1, USI_RSP_NAK}, engResp);
    rdc(`USI_IDX_LOW_FLAGS, 8'h08);
    apb(1'b1, `USI_IDX_EP0_STAT, 8'h20);
    fire(3'h2, 2'h0);
    chk("resp", {1'b1, USI_RSP_ACK}, engResp);
    rdc(`USI_IDX_LOW_FLAGS, 8'h04);
    // EP1 events in control configuration
    apb(1'b1, `USI_IDX_HIGH_FLAGS, 8'hFF);
    fire(3'h0, 2'h1);
    rdc(`USI_IDX_LOW_FLAGS, 8'h24);
    fire(3'h3, 2'h0);
    fire(3'h3, 2'h1);
    fire(3'h4, 2'h1);
    rdc(`USI_IDX_HIGH_FLAGS, 8'h4E);
    // Both endpoints off hides EP1 and EP2 stall and setup
    apb(1'b1, `USI_IDX_HIGH_FLAGS, 8'hFF);
    apb(1'b1, `USI_IDX_CTRL, 8'h80);
    fire(3'h3, 2'h1);
    fire(3'h3, 2'h2);
    fire(3'h4, 2'h1);
    rdc(`USI_IDX_HIGH_FLAGS, 8'h00);
    chk("engRst", 32'h2, rstCnt);
    fire(3'h5, 2'h0);
    rdc(`USI_IDX_ADDR, 8'h00);
    finishTest;
  end
endmodule : usb_sie_register_interface_tb
